// *** fault_monitor_map.svh ***
/*
  Constants for the safety I/O fault monitor: widths, counts, encodings.
  Assumes inclusion by bare name from the package and modules.
*/
`ifndef FAULT_MONITOR_MAP_SVH
`define FAULT_MONITOR_MAP_SVH
`define CUR_W 16
`define NUM_AI 3
`define NUM_DCH 4
`define NUM_OUT 8
`define NUM_AFAULT 2
`define TIME_W 24
`define CYCLE_NS 4
`define RST_ZERO_TIME 24'h00_0000
`define RST_ZERO_CUR 16'h0000
`define POLICY_FAILSAFE 2'h0
`define POLICY_AUTO 2'h1
`define POLICY_NONE 2'h2
`define POLICY_STATE 2'h3
`endif

// *** fault_monitor_pkg.sv ***
/*
  Types shared by the safety I/O fault monitor.
  Assumes fault_monitor_map.svh is on the include path.
*/
`include "fault_monitor_map.svh"
package fault_monitor_pkg;
  typedef enum logic [2:0] {
    reg_ll, reg_l, reg_n, reg_h, reg_hh
  } region_type;
  typedef enum logic [1:0] {
    oc_idle, oc_wait, oc_dead
  } oc_state_type;
endpackage : fault_monitor_pkg

// *** region_tracker.sv ***
/*
  Hysteresis region tracker for one analog channel.
  Assumes synchronous inputs and an already synchronised active low reset.
*/
`timescale 1ns/10ps
`include "fault_monitor_map.svh"
module region_tracker
  import fault_monitor_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_sync_b,
  // Measurement and settings.
  input wire logic [`CUR_W-1:0] current,
  input wire logic [`CUR_W-1:0] thr_ll,
  input wire logic [`CUR_W-1:0] thr_l,
  input wire logic [`CUR_W-1:0] thr_h,
  input wire logic [`CUR_W-1:0] thr_hh,
  input wire logic [`CUR_W-1:0] hyst,
  // Region flags, one hot.
  output logic [4:0] region_flags
);
  region_type region_r;
  region_type region_nxt;
  logic [`CUR_W:0] cur_x;

  function automatic logic above(input logic [`CUR_W:0] c,
                                 input logic [`CUR_W-1:0] t,
                                 input logic [`CUR_W-1:0] h);
    above = c > ({1'b0, t} + {1'b0, h});
  endfunction : above

  function automatic logic below(input logic [`CUR_W:0] c,
                                 input logic [`CUR_W-1:0] t,
                                 input logic [`CUR_W-1:0] h);
    below = (c + {1'b0, h}) < {1'b0, t};
  endfunction : below

  assign cur_x = {1'b0, current};

  // Moves one region at a time, only past threshold plus or minus band.
  always_comb begin
    region_nxt = region_r;
    case (region_r)
      reg_ll: if (above(cur_x, thr_ll, hyst)) region_nxt = reg_l;
      reg_l: begin
        if (above(cur_x, thr_l, hyst)) region_nxt = reg_n;
        else if (below(cur_x, thr_ll, hyst)) region_nxt = reg_ll;
      end
      reg_n: begin
        if (above(cur_x, thr_h, hyst)) region_nxt = reg_h;
        else if (below(cur_x, thr_l, hyst)) region_nxt = reg_l;
      end
      reg_h: begin
        if (above(cur_x, thr_hh, hyst)) region_nxt = reg_hh;
        else if (below(cur_x, thr_h, hyst)) region_nxt = reg_n;
      end
      reg_hh: if (below(cur_x, thr_hh, hyst)) region_nxt = reg_h;
      default: region_nxt = reg_n;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      region_r <= reg_n;
    end else begin
      region_r <= region_nxt;
    end
  end

  // Five Boolean region flags.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      region_flags <= 5'h04;
    end else begin
      region_flags <= 5'h01 << region_nxt;
    end
  end
endmodule : region_tracker

// *** safety_io_fault_monitor.sv ***
/*
  Safety I/O fault monitor: analog regions and mismatch, digital excess
  current policies, fail-safe latch and default output values.
  Assumes synchronous inputs; rst_b follows the external field supply.
*/
// Operation
// - Hysteresis band applies plus and minus around each threshold.
// - One hysteresis value serves all four thresholds; bands must not overlap.
// - Every redundant channel uses the same thresholds and hysteresis.
// - Mismatch is flagged only after persisting for the mismatch time.
// - Persistent mismatch reports a fault or a warning as configured.
// - A fault selected for fail-safe puts the module into fail-safe.
// - Fail-safe faults are hidden from the state machine; others offered.
// - Excess current de-energizes the channel and raises its fault.
// - Each test-pulsed input and each output has an excess current fault.
// - Fail-safe policy latches fail-safe until supply power cycle.
// - Auto policy clears fault after recovery time, repeating while excess.
// - No-recover policy holds channel off until power cycle, fault visible.
// - All outputs and variables take defaults when execution starts.
// - Outputs undefined by the active state take their default.
// - Compound state defaults apply on entry and fill undefined outputs.
// - Each analog channel is classed into five regions as Boolean flags.
`timescale 1ns/10ps
`include "fault_monitor_map.svh"
module safety_io_fault_monitor
  import fault_monitor_pkg::*;
(
  // Clock and reset from the field supply.
  input wire logic clk,
  input wire logic rst_b,
  // Analog channels and shared settings.
  input wire logic [`NUM_AI*`CUR_W-1:0] ai_current,
  input wire logic [`CUR_W-1:0] thr_ll,
  input wire logic [`CUR_W-1:0] thr_l,
  input wire logic [`CUR_W-1:0] thr_h,
  input wire logic [`CUR_W-1:0] thr_hh,
  input wire logic [`CUR_W-1:0] hyst,
  input wire logic triple_mode,
  input wire logic [`CUR_W-1:0] mismatch_current,
  input wire logic [`TIME_W-1:0] mismatch_cycles,
  input wire logic mismatch_is_warning,
  // Digital channels.
  input wire logic [`NUM_DCH-1:0] dch_configured,
  input wire logic [`NUM_DCH-1:0] dch_excess,
  input wire logic [`NUM_DCH-1:0] dch_request,
  input wire logic [2*`NUM_DCH-1:0] dch_policy,
  input wire logic [`TIME_W-1:0] recovery_cycles,
  // Fault routing for analog faults: fault then warning.
  input wire logic [`NUM_AFAULT-1:0] afault_to_failsafe,
  // State machine outputs.
  input wire logic run,
  input wire logic [`NUM_OUT-1:0] out_default,
  input wire logic compound_enter,
  input wire logic compound_active,
  input wire logic [`NUM_OUT-1:0] compound_default,
  input wire logic [`NUM_OUT-1:0] compound_defined,
  input wire logic [`NUM_OUT-1:0] state_value,
  input wire logic [`NUM_OUT-1:0] state_defined,
  // Status outputs.
  output logic [`NUM_AI*5-1:0] region_flags,
  output logic channel_mismatch_fault,
  output logic channel_mismatch_warning,
  output logic [`NUM_DCH-1:0] excess_current_fault,
  output logic [`NUM_DCH-1:0] dch_energize,
  output logic [`NUM_AFAULT+`NUM_DCH-1:0] sm_fault_inputs,
  output logic failsafe_active,
  output logic [`NUM_OUT-1:0] out_value
);
  logic rst_meta_r;
  logic rst_sync_b;
  logic [`TIME_W-1:0] mis_cnt_r;
  logic mis_now;
  logic mis_hit_r;
  logic [`NUM_OUT-1:0] comp_def_r;
  logic [`NUM_OUT-1:0] out_nxt;
  logic fs_nxt;
  logic [`TIME_W-1:0] rec_cnt_r [`NUM_DCH];
  oc_state_type oc_r [`NUM_DCH];

  function automatic logic [`CUR_W-1:0] absdiff(input logic [`CUR_W-1:0] a,
                                                input logic [`CUR_W-1:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction : absdiff

  function automatic logic [1:0] policy_of(input int i,
                                           input logic [2*`NUM_DCH-1:0] p);
    policy_of = p[2*i +: 2];
  endfunction : policy_of

  // Reset release through two flip-flops.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // Same shared settings feed each channel's tracker.
  for (genvar c = 0; c < `NUM_AI; c++) begin : g_ai
    region_tracker u_trk (
      .clk(clk),
      .rst_sync_b(rst_sync_b),
      .current(ai_current[c*`CUR_W +: `CUR_W]),
      .thr_ll(thr_ll),
      .thr_l(thr_l),
      .thr_h(thr_h),
      .thr_hh(thr_hh),
      .hyst(hyst),
      .region_flags(region_flags[c*5 +: 5])
    );
  end

  // Pairwise difference beyond the limit among the active channels.
  always_comb begin
    mis_now = absdiff(ai_current[0 +: `CUR_W],
                      ai_current[`CUR_W +: `CUR_W]) > mismatch_current;
    if (triple_mode) begin
      mis_now = mis_now
        | (absdiff(ai_current[0 +: `CUR_W],
                   ai_current[2*`CUR_W +: `CUR_W]) > mismatch_current)
        | (absdiff(ai_current[`CUR_W +: `CUR_W],
                   ai_current[2*`CUR_W +: `CUR_W]) > mismatch_current);
    end
  end

  // Persistence timer; restarts whenever the difference goes away.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mis_cnt_r <= `RST_ZERO_TIME;
      mis_hit_r <= 1'b0;
    end else if (!mis_now) begin
      mis_cnt_r <= `RST_ZERO_TIME;
      mis_hit_r <= 1'b0;
    end else if (mis_cnt_r >= mismatch_cycles) begin
      mis_hit_r <= 1'b1;
    end else begin
      mis_cnt_r <= mis_cnt_r + 1'b1;
    end
  end

  // Fault or warning by configuration.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      channel_mismatch_fault <= 1'b0;
      channel_mismatch_warning <= 1'b0;
    end else begin
      channel_mismatch_fault <= mis_hit_r & ~mismatch_is_warning;
      channel_mismatch_warning <= mis_hit_r & mismatch_is_warning;
    end
  end

  // Excess current policy per digital channel.
  for (genvar d = 0; d < `NUM_DCH; d++) begin : g_dch
    always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        oc_r[d] <= oc_idle;
        rec_cnt_r[d] <= `RST_ZERO_TIME;
      end else begin
        case (oc_r[d])
          oc_idle: begin
            if (dch_configured[d] && dch_excess[d]) begin
              rec_cnt_r[d] <= `RST_ZERO_TIME;
              if (policy_of(d, dch_policy) == `POLICY_AUTO) begin
                oc_r[d] <= oc_wait;
              end else begin
                oc_r[d] <= oc_dead;
              end
            end
          end
          oc_wait: begin
            if (rec_cnt_r[d] >= recovery_cycles) begin
              oc_r[d] <= oc_idle;
            end else begin
              rec_cnt_r[d] <= rec_cnt_r[d] + 1'b1;
            end
          end
          oc_dead: oc_r[d] <= oc_dead;
          default: oc_r[d] <= oc_idle;
        endcase
      end
    end

    // Channel off while faulted; fault shown while not idle.
    always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        dch_energize[d] <= 1'b0;
        excess_current_fault[d] <= 1'b0;
      end else begin
        excess_current_fault[d] <= (oc_r[d] != oc_idle)
          || (dch_configured[d] && dch_excess[d]);
        dch_energize[d] <= dch_request[d] && oc_r[d] == oc_idle
          && !(dch_configured[d] && dch_excess[d]) && !failsafe_active
          && !fs_nxt;
      end
    end
  end

  // Fail-safe latch: routed analog faults and fail-safe policy channels.
  always_comb begin
    fs_nxt = (afault_to_failsafe[0] & channel_mismatch_fault)
           | (afault_to_failsafe[1] & channel_mismatch_warning);
    for (int i = 0; i < `NUM_DCH; i++) begin
      if (policy_of(i, dch_policy) == `POLICY_FAILSAFE
          && oc_r[i] == oc_dead) begin
        fs_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      failsafe_active <= 1'b0;
    end else if (fs_nxt) begin
      failsafe_active <= 1'b1;
    end
  end

  // Unrouted faults go to the state machine; routed ones are withheld.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sm_fault_inputs <= '0;
    end else begin
      sm_fault_inputs[0] <= channel_mismatch_fault
                            & ~afault_to_failsafe[0];
      sm_fault_inputs[1] <= channel_mismatch_warning
                            & ~afault_to_failsafe[1];
      for (int i = 0; i < `NUM_DCH; i++) begin
        sm_fault_inputs[`NUM_AFAULT+i] <= excess_current_fault[i]
          & (policy_of(i, dch_policy) != `POLICY_FAILSAFE);
      end
    end
  end

  // Compound defaults captured on entry.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      comp_def_r <= '0;
    end else if (compound_enter) begin
      comp_def_r <= compound_default;
    end
  end

  // Innermost defined value wins, else compound default, else default.
  always_comb begin
    for (int i = 0; i < `NUM_OUT; i++) begin
      if (!run) begin
        out_nxt[i] = out_default[i];
      end else if (state_defined[i]) begin
        out_nxt[i] = state_value[i];
      end else if (compound_active && compound_defined[i]) begin
        out_nxt[i] = compound_enter ? compound_default[i]
                                    : comp_def_r[i];
      end else begin
        out_nxt[i] = out_default[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_value <= '0;
    end else begin
      out_value <= out_nxt;
    end
  end
endmodule : safety_io_fault_monitor

// *** safety_io_fault_monitor_assertions.sv ***
/*
  Port checker for the safety I/O fault monitor, bound to its top module.
  Assumes the map header is on the include path.
*/
`timescale 1ns/10ps
`include "fault_monitor_map.svh"
module safety_io_fault_monitor_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Watched inputs.
  input wire logic [`NUM_AI*`CUR_W-1:0] ai_current,
  input wire logic triple_mode,
  input wire logic [`CUR_W-1:0] mismatch_current,
  input wire logic mismatch_is_warning,
  input wire logic [`NUM_DCH-1:0] dch_configured,
  input wire logic [`NUM_DCH-1:0] dch_excess,
  input wire logic [2*`NUM_DCH-1:0] dch_policy,
  input wire logic [`NUM_AFAULT-1:0] afault_to_failsafe,
  input wire logic run,
  input wire logic [`NUM_OUT-1:0] out_default,
  // Watched outputs.
  input wire logic [`NUM_AI*5-1:0] region_flags,
  input wire logic channel_mismatch_fault,
  input wire logic channel_mismatch_warning,
  input wire logic [`NUM_DCH-1:0] excess_current_fault,
  input wire logic [`NUM_DCH-1:0] dch_energize,
  input wire logic [`NUM_AFAULT+`NUM_DCH-1:0] sm_fault_inputs,
  input wire logic failsafe_active,
  input wire logic [`NUM_OUT-1:0] out_value
);
  logic [1:0] age_r;
  logic ok;
  logic dif;
  function automatic logic far(logic [`CUR_W-1:0] a, logic [`CUR_W-1:0] b);
    return (a > b ? a - b : b - a) > mismatch_current;
  endfunction : far
  assign ok = (age_r == 2'h3);
  assign dif = far(ai_current[0+:16], ai_current[16+:16]) || (triple_mode
    && (far(ai_current[0+:16], ai_current[32+:16])
    || far(ai_current[16+:16], ai_current[32+:16])));
  // Counts edges since reset release so checks start once logic is live.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      age_r <= 2'h0;
    else if (!ok)
      age_r <= age_r + 2'h1;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence calm; !dif [*4]; endsequence
  sequence routed; afault_to_failsafe[0] [*3]; endsequence
  chk_region_one_hot: assert property ($onehot(region_flags[4:0]))
    else $error("region flags not one hot");
  chk_excess_trip: assert property (ok && dch_configured[1]
    && dch_excess[1] |=> excess_current_fault[1] && !dch_energize[1])
    else $error("excess current not acted on");
  chk_norecover_hold: assert property (excess_current_fault[1]
    && dch_policy[3:2] == `POLICY_NONE |=> excess_current_fault[1]
    && !dch_energize[1]) else $error("no-recover channel released");
  chk_failsafe_keep: assert property (failsafe_active |=>
    failsafe_active && dch_energize == 4'h0) else $error("fail-safe left");
  chk_failsafe_trip: assert property (ok && dch_configured[3]
    && dch_excess[3] && dch_policy[7:6] == `POLICY_FAILSAFE
    |-> ##[1:3] failsafe_active) else $error("fail-safe not entered");
  chk_route_hidden: assert property (routed |-> !sm_fault_inputs[0])
    else $error("routed fault offered to state machine");
  chk_mismatch_calm: assert property (calm |-> !channel_mismatch_fault
    && !channel_mismatch_warning) else $error("mismatch without cause");
  chk_warn_select: assert property (channel_mismatch_warning |->
    !channel_mismatch_fault && $past(mismatch_is_warning))
    else $error("wrong mismatch report kind");
  chk_out_default: assert property (ok && !run |=>
    out_value == $past(out_default)) else $error("default not driven");
endmodule : safety_io_fault_monitor_checker

bind safety_io_fault_monitor safety_io_fault_monitor_checker
  safety_io_fault_monitor_checker_inst (.*);

// *** field_channel_model.sv ***
/*
  Field sensors and loads: analog loop currents and shorted digital loads.
  Assumes the bench sets currents and shorts between clock edges.
*/
`timescale 1ns/10ps
`include "fault_monitor_map.svh"
module field_channel_model (
  // Clock.
  input wire logic clk,
  // Bench settings.
  input wire logic [`NUM_AI*`CUR_W-1:0] cur_set,
  input wire logic [`NUM_DCH-1:0] short_en,
  // Monitor side.
  input wire logic [`NUM_DCH-1:0] dch_energize,
  output logic [`NUM_AI*`CUR_W-1:0] ai_current,
  output logic [`NUM_DCH-1:0] dch_excess
);
  // A shorted load draws excess current only while it is energized.
  // Updating on the rising edge keeps the bench's falling-edge writes
  // free of ordering races.
  always @(posedge clk) begin
    ai_current <= cur_set;
    dch_excess <= dch_energize & short_en;
  end
endmodule : field_channel_model

// *** safety_io_fault_monitor_tb_top.sv ***
/*
  Self-checking bench for the safety I/O fault monitor.
  Assumes the design, checker and field model are compiled before it.
*/
`timescale 1ns/10ps
`include "fault_monitor_map.svh"
module safety_io_fault_monitor_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [47:0] cur_set, ai_current;
  logic [3:0] short_en, dch_excess, dch_configured, dch_request;
  logic [15:0] thr_ll, thr_l, thr_h, thr_hh, hyst, mismatch_current;
  logic triple_mode, mismatch_is_warning, run, compound_enter;
  logic compound_active, channel_mismatch_fault, channel_mismatch_warning;
  logic failsafe_active;
  logic [23:0] mismatch_cycles, recovery_cycles;
  logic [7:0] dch_policy, out_default, compound_default, compound_defined;
  logic [7:0] state_value, state_defined, out_value;
  logic [1:0] afault_to_failsafe;
  logic [14:0] region_flags;
  logic [3:0] excess_current_fault, dch_energize;
  logic [5:0] sm_fault_inputs;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  safety_io_fault_monitor safety_io_fault_monitor_inst (.*);
  field_channel_model field_channel_model_inst (.*);
  always #2 clk = ~clk;
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic power_cycle;
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(3);
  endtask : power_cycle
  task automatic t_region;
    logic [15:0] cur[9] = '{16'h2ee0, 16'h4e84, 16'h4e85, 16'h526d,
      16'h51d6, 16'h51a3, 16'h0f3c, 16'h0f3b, 16'h0b53};
    logic [4:0] reg_x[9] = '{5'h04, 5'h04, 5'h08, 5'h10, 5'h10, 5'h08,
      5'h04, 5'h02, 5'h01};
    for (int i = 0; i < 9; i++) begin
      cur_set = {3{cur[i]}};
      tick(6);
      chk("region", {3{reg_x[i]}}, region_flags);
    end
  endtask : t_region
  task automatic t_mismatch;
    cur_set = {16'h2ee0, 16'h30d4, 16'h2ee0};
    tick(25);
    chk("limit", 2'h0, {channel_mismatch_fault, channel_mismatch_warning});
    for (int w = 0; w < 2; w++) begin
      mismatch_is_warning = w[0];
      cur_set = {16'h2ee0, 16'h3138, 16'h2ee0};
      tick(20);
      chk("early", 2'h0, {channel_mismatch_fault, channel_mismatch_warning});
      tick(5);
      chk("flag", w ? 2'h1 : 2'h2, {channel_mismatch_fault, channel_mismatch_warning});
      chk("offered", w ? 2'h2 : 2'h1, sm_fault_inputs[1:0]);
      cur_set = {3{16'h2ee0}};
      tick(6);
    end
    triple_mode = 1'b1;
    cur_set = {16'h3138, {2{16'h2ee0}}};
    tick(25);
    chk("third", 1'h1, channel_mismatch_warning);
    cur_set = {3{16'h2ee0}};
    triple_mode = 1'b0;
    tick(6);
  endtask : t_mismatch
  task automatic t_excess;
    int rises;
    logic prev;
    rises = 0;
    prev = 1'b0;
    short_en = 4'h7;
    tick(4);
    chk("unconfigured", 1'h0, excess_current_fault[2]);
    chk("held", 2'h2, {excess_current_fault[1], dch_energize[1]});
    chk("sm excess", 1'h1, sm_fault_inputs[3]);
    for (int i = 0; i < 80; i++) begin
      tick(1);
      rises += excess_current_fault[0] & !prev;
      prev = excess_current_fault[0];
    end
    chk("retrips", 1'h1, rises >= 3);
    short_en = 4'h4;
    dch_configured = 4'hf;
    tick(30);
    chk("recovered", 2'h1, {excess_current_fault[0], dch_energize[0]});
    chk("policy three", 2'h2, {excess_current_fault[2], dch_energize[2]});
  endtask : t_excess
  task automatic t_failsafe;
    for (int i = 0; i < 3; i++) begin
      short_en = 4'h0;
      mismatch_is_warning = (i == 1);
      power_cycle();
      chk("cleared", 2'h0, {failsafe_active, excess_current_fault[1]});
      afault_to_failsafe = i ? 2'h3 : 2'h0;
      short_en = i ? 4'h0 : 4'h8;
      cur_set = i ? {16'h2ee0, 16'h3138, 16'h2ee0} : {3{16'h2ee0}};
      tick(30);
      chk("failsafe", 1'h1, failsafe_active);
      chk("energize", 4'h0, dch_energize);
      chk("hidden", 6'h00, sm_fault_inputs & (i ? 6'h03 : 6'h20));
    end
    short_en = 4'h0;
    cur_set = {3{16'h2ee0}};
    power_cycle();
  endtask : t_failsafe
  task automatic t_outputs;
    tick(2);
    chk("default", 8'hc3, out_value);
    run = 1'b1;
    state_defined = 8'h0f;
    state_value = 8'h05;
    compound_active = 1'b1;
    compound_defined = 8'h30;
    compound_default = 8'h20;
    compound_enter = 1'b1;
    tick(1);
    compound_enter = 1'b0;
    compound_default = 8'h10;
    tick(2);
    chk("merged", 8'he5, out_value);
  endtask : t_outputs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    cur_set = {3{16'h2ee0}};
    short_en = 4'h0;
    thr_ll = 16'h0bb8;
    thr_l = 16'h0fa0;
    thr_h = 16'h4e20;
    thr_hh = 16'h5208;
    hyst = 16'h0064;
    triple_mode = 1'b0;
    mismatch_current = 16'h01f4;
    mismatch_cycles = 24'h00_0014;
    mismatch_is_warning = 1'b0;
    dch_configured = 4'hb;
    dch_request = 4'hf;
    dch_policy = {`POLICY_FAILSAFE, `POLICY_STATE, `POLICY_NONE, `POLICY_AUTO};
    recovery_cycles = 24'h00_000a;
    afault_to_failsafe = 2'h0;
    run = 1'b0;
    out_default = 8'hc3;
    compound_enter = 1'b0;
    compound_active = 1'b0;
    compound_default = 8'h00;
    compound_defined = 8'h00;
    state_value = 8'h00;
    state_defined = 8'h00;
    power_cycle();
    t_region();
    t_mismatch();
    t_excess();
    t_failsafe();
    t_outputs();
    conclude();
  end
endmodule : safety_io_fault_monitor_tb_top
